//--- logic/pin_mux_pkg.sv
`default_nettype none
package pin_mux_pkg;

    localparam int ADDR_W = 6;

    // register byte offsets
    localparam logic [5:0] SYS_CFG_OFS = 6'h00;
    localparam logic [5:0] INT_PIN_OFS = 6'h04;
    localparam logic [5:0] PA_DATA_OFS = 6'h08;
    localparam logic [5:0] PA_DIR_OFS = 6'h0c;
    localparam logic [5:0] PC_DATA_OFS = 6'h10;
    localparam logic [5:0] PC_DIR_OFS = 6'h14;
    localparam logic [5:0] PA_PINS_OFS = 6'h18;
    localparam logic [5:0] PC_PINS_OFS = 6'h1c;

    // field positions
    localparam int HOST_MODE_BIT = 1;
    localparam int TRI_ALT_BIT = 2;
    localparam int PORT_C_BIT = 7;
    localparam int CHAIN_OUT_BIT = 2;
    localparam int MEM_REQ_BIT = 3;

    // reset values
    localparam logic [7:0] SYS_CFG_RST = 8'h00;
    localparam logic [7:0] INT_PIN_RST = 8'h00;
    localparam logic [7:0] PORT_DATA_RST = 8'h00;
    localparam logic [7:0] PORT_DIR_RST = 8'h00;

    // port c lines 7 and 6 can never be outputs
    localparam logic [7:0] PC_IN_ONLY = 8'hc0;

    // synchronised pin levels, one field per pin group
    typedef struct packed {
        logic [1:0] intN;
        logic chain;
        logic wr;
        logic [4:0] cha;
        logic [2:0] tri3;
        logic [6:0] chb;
        logic [7:0] pa;
    } pin_in_s;

    typedef struct packed {
        logic [6:0] o;
        logic [6:0] oe;
        logic dtrReqN;
        logic waitReqN;
        logic rtsN;
    } chan_b_out_s;

    typedef struct packed {
        logic [7:0] data;
        logic dataOe;
        logic ddisN;
        logic intr;
        logic txRdyN;
        logic rxRdyN;
    } host_out_s;

    typedef struct packed {
        logic [7:0] data;
        logic [2:0] addr;
        logic csN;
        logic rdN;
        logic wrN;
    } host_in_s;

    typedef struct packed {
        logic waitReqN;
        logic dtrReqN;
        logic rtsN;
    } chan_a_out_s;

    typedef struct packed {
        logic ctsN;
        logic dcdN;
        logic syncN;
    } chan_a_in_s;

    typedef struct packed {
        logic ckaO;
        logic ckaOe;
        logic tend1N;
        logic mwrN;
        logic mrdN;
        logic mreqN;
        logic chain_enable_output;
    } mpu_out_s;

    typedef struct packed {
        logic ckaI;
        logic dreq1N;
        logic chain_enable_input;
        logic int1N;
        logic int2N;
    } mpu_in_s;

endpackage
`default_nettype wire

//--- logic/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '1
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r, s2_r, s3_r;
    logic [W-1:0] agree;

    // a bit only moves once two late stages agree: filters a runt glitch
    assign agree = ~(s2_r ^ s3_r);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s1_r <= RST;
            s2_r <= RST;
            s3_r <= RST;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q <= RST;
        end else begin
            q <= (s3_r & agree) | (q & ~agree);
        end
    end
endmodule // pin_sync
`default_nettype wire

//--- logic/pin_select.sv
`timescale 1ns/10ps
`default_nettype none
module pin_select #(
    parameter int W = 1,
    parameter logic [W-1:0] INACT = '1
) (
    input wire logic [1:0] sel,
    input wire logic [W-1:0] o0,
    input wire logic [W-1:0] e0,
    input wire logic [W-1:0] o1,
    input wire logic [W-1:0] e1,
    input wire logic [W-1:0] o2,
    input wire logic [W-1:0] e2,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] pinOut,
    output logic [W-1:0] pinOe,
    output logic [W-1:0] i0,
    output logic [W-1:0] i1,
    output logic [W-1:0] i2
);
    always_comb begin
        case (sel)
            2'h1: begin
                pinOut = o1;
                pinOe = e1;
            end
            2'h2: begin
                pinOut = o2;
                pinOe = e2;
            end
            default: begin
                pinOut = o0;
                pinOe = e0;
            end
        endcase
    end

    // units that lost the pin see a quiet level, not the pin
    assign i0 = (sel == 2'h0) ? pinIn : INACT;
    assign i1 = (sel == 2'h1) ? pinIn : INACT;
    assign i2 = (sel == 2'h2) ? pinIn : INACT;
endmodule // pin_select
`default_nettype wire

//--- logic/shared_pin_function_mux.sv
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module shared_pin_function_mux (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [pin_mux_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [7:0] paPinIn,
    output logic [7:0] paPinOut,
    output logic [7:0] paPinOe,
    input wire logic [6:0] chbPinIn,
    output logic [6:0] chbPinOut,
    output logic [6:0] chbPinOe,
    input wire logic [2:0] triPinIn,
    output logic [2:0] triPinOut,
    output logic [2:0] triPinOe,
    input wire logic [4:0] chaPinIn,
    output logic [4:0] chaPinOut,
    output logic [4:0] chaPinOe,
    input wire logic wrPinIn,
    output logic wrPinOut,
    output logic wrPinOe,
    input wire logic chainPinIn,
    output logic chainPinOut,
    output logic chainPinOe,
    output logic mrdPinOut,
    input wire logic [1:0] intPinIn,
    input wire pin_mux_pkg::chan_b_out_s chbOut,
    output pin_mux_pkg::host_in_s hostIn,
    input wire pin_mux_pkg::host_out_s hostOut,
    output logic [6:0] chbIn,
    input wire pin_mux_pkg::chan_a_out_s chaOut,
    output pin_mux_pkg::chan_a_in_s chaIn,
    input wire pin_mux_pkg::mpu_out_s mpuOut,
    output pin_mux_pkg::mpu_in_s mpuIn
);
    import pin_mux_pkg::*;

    logic [7:0] sysCfg_r, intPin_r, paData_r, paDir_r, pcData_r, pcDir_r;
    logic ack_r;
    logic [31:0] rdData_r, rdData_nxt;
    logic req, wrEn;
    logic hostMode, portC, chainOut, memReq;
    logic [1:0] triSel, wrSel;
    pin_in_s rawIn, syncIn;
    logic [7:0] paPortIn, pcPins;
    logic [6:0] hostBusIn;
    logic [4:0] chaUnitIn, pcLow;
    logic [2:0] triMpuIn;
    logic pc2In;

    ////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle on every access

    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_r;
    assign wrEn = avs_write & ack_r & avs_byteenable[0];
    assign avs_readdata = rdData_r;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sysCfg_r <= SYS_CFG_RST;
            intPin_r <= INT_PIN_RST;
            paData_r <= PORT_DATA_RST;
            paDir_r <= PORT_DIR_RST;
            pcData_r <= PORT_DATA_RST;
            pcDir_r <= PORT_DIR_RST;
        end else if (wrEn) begin
            case (avs_address)
                SYS_CFG_OFS: sysCfg_r <= avs_writedata[7:0];
                INT_PIN_OFS: intPin_r <= avs_writedata[7:0];
                PA_DATA_OFS: paData_r <= avs_writedata[7:0];
                PA_DIR_OFS: paDir_r <= avs_writedata[7:0];
                PC_DATA_OFS: pcData_r <= avs_writedata[7:0];
                PC_DIR_OFS:
                    pcDir_r <= avs_writedata[7:0] & ~PC_IN_ONLY;
                default: ;
            endcase
        end
    end

    // unmapped addresses read zero and ignore writes
    always_comb begin
        rdData_nxt = 32'h0000_0000;
        case (avs_address)
            SYS_CFG_OFS: rdData_nxt[7:0] = sysCfg_r;
            INT_PIN_OFS: rdData_nxt[7:0] = intPin_r;
            PA_DATA_OFS: rdData_nxt[7:0] = paData_r;
            PA_DIR_OFS: rdData_nxt[7:0] = paDir_r;
            PC_DATA_OFS: rdData_nxt[7:0] = pcData_r;
            PC_DIR_OFS: rdData_nxt[7:0] = pcDir_r;
            PA_PINS_OFS: rdData_nxt[7:0] = paPortIn;
            PC_PINS_OFS: rdData_nxt[7:0] = pcPins;
            default: rdData_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdData_r <= 32'h0000_0000;
        end else if (avs_read & ~ack_r) begin
            rdData_r <= rdData_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // selection decode

    assign hostMode = sysCfg_r[HOST_MODE_BIT];
    assign portC = sysCfg_r[PORT_C_BIT];
    assign chainOut = intPin_r[CHAIN_OUT_BIT];
    assign memReq = intPin_r[MEM_REQ_BIT];

    // host mode outranks bit 2 on the three-function pins
    assign triSel = hostMode ? 2'h2 :
        (sysCfg_r[TRI_ALT_BIT] ? 2'h1 : 2'h0);
    assign wrSel = !memReq ? 2'h0 : (portC ? 2'h1 : 2'h2);

    ////////////////////////////////////////////////////////////////////
    // every pin input is synchronised before anyone looks at it

    assign rawIn = {intPinIn, chainPinIn, wrPinIn, chaPinIn, triPinIn,
        chbPinIn, paPinIn};

    pin_sync #(.W($bits(pin_in_s)), .RST('1)) u_sync (
        .clock(clock),
        .nrst(nrst),
        .d(rawIn),
        .q(syncIn)
    );

    ////////////////////////////////////////////////////////////////////
    // pin groups

    pin_select #(.W(8), .INACT(8'h00)) u_pa (
        .sel({1'b0, hostMode}),
        .o0(paData_r),
        .e0(paDir_r),
        .o1(hostOut.data),
        .e1({8{hostOut.dataOe}}),
        .o2(8'h00),
        .e2(8'h00),
        .pinIn(syncIn.pa),
        .pinOut(paPinOut),
        .pinOe(paPinOe),
        .i0(paPortIn),
        .i1(hostIn.data),
        .i2()
    );

    pin_select #(.W(7), .INACT(7'h7f)) u_chb (
        .sel({1'b0, hostMode}),
        .o0(chbOut.o),
        .e0(chbOut.oe),
        .o1({6'h3f, hostOut.ddisN}),
        .e1(7'h01),
        .o2(7'h00),
        .e2(7'h00),
        .pinIn(syncIn.chb),
        .pinOut(chbPinOut),
        .pinOe(chbPinOe),
        .i0(chbIn),
        .i1(hostBusIn),
        .i2()
    );

    assign hostIn.addr = {hostBusIn[3], hostBusIn[1], hostBusIn[2]};
    assign hostIn.csN = hostBusIn[4];
    assign hostIn.wrN = hostBusIn[5];
    assign hostIn.rdN = hostBusIn[6];

    pin_select #(.W(3), .INACT(3'h7)) u_tri (
        .sel(triSel),
        .o0({mpuOut.tend1N, 1'b1, mpuOut.ckaO}),
        .e0({1'b1, 1'b0, mpuOut.ckaOe}),
        .o1({chbOut.rtsN, chbOut.waitReqN, chbOut.dtrReqN}),
        .e1(3'h7),
        .o2({hostOut.rxRdyN, hostOut.txRdyN, hostOut.intr}),
        .e2(3'h7),
        .pinIn(syncIn.tri3),
        .pinOut(triPinOut),
        .pinOe(triPinOe),
        .i0(triMpuIn),
        .i1(),
        .i2()
    );

    // channel A order: dcd/pc0, cts/pc1, dtr/pc3, sync/pc4, wait/pc5
    pin_select #(.W(5), .INACT(5'h1f)) u_cha (
        .sel({1'b0, portC}),
        .o0({chaOut.waitReqN, 1'b1, chaOut.dtrReqN, 2'h3}),
        .e0(5'h14),
        .o1({pcData_r[5:3], pcData_r[1:0]}),
        .e1({pcDir_r[5:3], pcDir_r[1:0]}),
        .o2(5'h00),
        .e2(5'h00),
        .pinIn(syncIn.cha),
        .pinOut(chaPinOut),
        .pinOe(chaPinOe),
        .i0(chaUnitIn),
        .i1(pcLow),
        .i2()
    );

    assign chaIn.dcdN = chaUnitIn[0];
    assign chaIn.ctsN = chaUnitIn[1];
    assign chaIn.syncN = chaUnitIn[3];

    pin_select #(.W(1), .INACT(1'b1)) u_wr (
        .sel(wrSel),
        .o0(mpuOut.mwrN),
        .e0(1'b1),
        .o1(pcData_r[2]),
        .e1(pcDir_r[2]),
        .o2(chaOut.rtsN),
        .e2(1'b1),
        .pinIn(syncIn.wr),
        .pinOut(wrPinOut),
        .pinOe(wrPinOe),
        .i0(),
        .i1(pc2In),
        .i2()
    );

    // interrupt lines reach the port only as reads; no output path exists
    assign pcPins = {syncIn.intN, pcLow[4:2], pc2In, pcLow[1:0]};

    assign mrdPinOut = memReq ? mpuOut.mreqN : mpuOut.mrdN;
    assign chainPinOut = mpuOut.chain_enable_output;
    assign chainPinOe = chainOut;
    // high keeps the chain open when the pin is taken for the output
    assign mpuIn.chain_enable_input = chainOut ? 1'b1 : syncIn.chain;
    assign mpuIn.ckaI = triMpuIn[0];
    assign mpuIn.dreq1N = triMpuIn[1];
    assign mpuIn.int1N = syncIn.intN[0];
    assign mpuIn.int2N = syncIn.intN[1];

    ////////////////////////////////////////////////////////////////////
    // checks

    property p_host_take;
        @(posedge clock) disable iff (!nrst)
        (wrEn && avs_address == SYS_CFG_OFS && avs_writedata[1])
            |=> (paPinOe == {8{hostOut.dataOe}}) && (chbPinOe == 7'h01);
    endproperty
    a_host_take: assert property (p_host_take)
        else $error("host mode write did not hand over pins");

    property p_modem_port;
        @(posedge clock) disable iff (!nrst)
        portC |-> chaPinOe == {pcDir_r[5:3], pcDir_r[1:0]};
    endproperty
    a_modem_port: assert property (p_modem_port)
        else $error("port C lines not driven from port registers");

    property p_tri_pick;
        @(posedge clock) disable iff (!nrst)
        (!hostMode && sysCfg_r[TRI_ALT_BIT]) |->
            triPinOut == {chbOut.rtsN, chbOut.waitReqN, chbOut.dtrReqN};
    endproperty
    a_tri_pick: assert property (p_tri_pick)
        else $error("three-function pins missed second function");

    property p_mem_strobe;
        @(posedge clock) disable iff (!nrst)
        $rose(memReq) |-> mrdPinOut == mpuOut.mreqN;
    endproperty
    a_mem_strobe: assert property (p_mem_strobe)
        else $error("read strobe pin not moved to memory request");

    property p_chain_dir;
        @(posedge clock) disable iff (!nrst)
        (chainPinOe == chainOut) and (chainOut |-> mpuIn.chain_enable_input);
    endproperty
    a_chain_dir: assert property (p_chain_dir)
        else $error("chain pin direction wrong");

    property p_int_read;
        @(posedge clock) disable iff (!nrst)
        // the synchroniser shows reset ones until four edges after release
        ($past(nrst, 4) && $past(intPinIn, 3) == $past(intPinIn, 4))
            |-> pcPins[7:6] == $past(intPinIn, 3) && pcDir_r[7:6] == 2'h0;
    endproperty
    a_int_read: assert property (p_int_read)
        else $error("port C 7:6 does not follow interrupt pins");

    property p_wr_pair;
        @(posedge clock) disable iff (!nrst)
        (memReq && !portC) |-> wrPinOut == chaOut.rtsN && wrPinOe;
    endproperty
    a_wr_pair: assert property (p_wr_pair)
        else $error("write strobe pin not given to request-to-send");

    property p_loser_quiet;
        @(posedge clock) disable iff (!nrst)
        hostMode |-> chbIn == 7'h7f && paPortIn == 8'h00;
    endproperty
    a_loser_quiet: assert property (p_loser_quiet)
        else $error("unit that lost its pins still sees them");

    property p_bus_answer;
        @(posedge clock) disable iff (!nrst)
        $rose(req) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus answer not after exactly one wait cycle");

endmodule // shared_pin_function_mux
`default_nettype wire

//--- verification/board_pins.sv
`timescale 1ns/10ps
`default_nettype none
// board side of a group of shared pins: a driven pin shows the device value,
// a released pin shows what the outside peripheral puts on it
module board_pins #(
    parameter int W = 1
) (
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] ext,
    output logic [W-1:0] lvl
);
    // per bit; never left floating, so no unknown reaches the synchroniser
    assign lvl = (out & oe) | (ext & ~oe);
endmodule // board_pins
`default_nettype wire

//--- verification/shared_pin_function_mux_tb.sv
`timescale 1ns/10ps
`default_nettype none
module shared_pin_function_mux_tb;
    import pin_mux_pkg::*;
    logic clock;
    logic nrst;
    logic [ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [7:0] paPinIn, paPinOut, paPinOe, paExt;
    logic [6:0] chbPinIn, chbPinOut, chbPinOe, chbExt, chbIn;
    logic [2:0] triPinIn, triPinOut, triPinOe, triExt;
    logic [4:0] chaPinIn, chaPinOut, chaPinOe, chaExt;
    logic wrPinIn, wrPinOut, wrPinOe, wrExt;
    logic chainPinIn, chainPinOut, chainPinOe, chainExt, mrdPinOut;
    logic [1:0] intPinIn;
    chan_b_out_s chbOut;
    host_in_s hostIn;
    host_out_s hostOut;
    chan_a_out_s chaOut;
    chan_a_in_s chaIn;
    mpu_out_s mpuOut;
    mpu_in_s mpuIn;
    logic [31:0] rdat;
    int errTotal = 0;
    int cmpCount = 0;

    ////////////////////////////////////////////////////////////////////////
    shared_pin_function_mux DUT (
        .clock(clock), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .paPinIn(paPinIn), .paPinOut(paPinOut), .paPinOe(paPinOe),
        .chbPinIn(chbPinIn), .chbPinOut(chbPinOut), .chbPinOe(chbPinOe),
        .triPinIn(triPinIn), .triPinOut(triPinOut), .triPinOe(triPinOe),
        .chaPinIn(chaPinIn), .chaPinOut(chaPinOut), .chaPinOe(chaPinOe),
        .wrPinIn(wrPinIn), .wrPinOut(wrPinOut), .wrPinOe(wrPinOe),
        .chainPinIn(chainPinIn), .chainPinOut(chainPinOut),
        .chainPinOe(chainPinOe), .mrdPinOut(mrdPinOut),
        .intPinIn(intPinIn), .chbOut(chbOut), .hostIn(hostIn),
        .hostOut(hostOut), .chbIn(chbIn), .chaOut(chaOut), .chaIn(chaIn),
        .mpuOut(mpuOut), .mpuIn(mpuIn)
    );
    board_pins #(.W(8)) uPa (.out(paPinOut), .oe(paPinOe), .ext(paExt),
        .lvl(paPinIn));
    board_pins #(.W(7)) uChb (.out(chbPinOut), .oe(chbPinOe), .ext(chbExt),
        .lvl(chbPinIn));
    board_pins #(.W(3)) uTri (.out(triPinOut), .oe(triPinOe), .ext(triExt),
        .lvl(triPinIn));
    board_pins #(.W(5)) uCha (.out(chaPinOut), .oe(chaPinOe), .ext(chaExt),
        .lvl(chaPinIn));
    board_pins #(.W(1)) uWr (.out(wrPinOut), .oe(wrPinOe), .ext(wrExt),
        .lvl(wrPinIn));
    board_pins #(.W(1)) uChain (.out(chainPinOut), .oe(chainPinOe),
        .ext(chainExt), .lvl(chainPinIn));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errTotal++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmpCount, errTotal);
        if (errTotal == 0 && cmpCount > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // one bus cycle; only the watchdog ends the wait on a dead slave
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        avs_address <= a;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= {24'h000000, d};
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // one wait cycle: the answer comes at the second edge
        check(n, 32'd2);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic cfg(input logic [7:0] s, input logic [7:0] p);
        wr(SYS_CFG_OFS, s);
        wr(INT_PIN_OFS, p);
    endtask

    // pins pass a 3-flop synchroniser and a filter flop, so give inputs 5 edges to land
    task automatic settle;
        repeat (5) @(posedge clock);
        @(negedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [5:0] ofs [6];
        ofs = '{SYS_CFG_OFS, INT_PIN_OFS, PA_DATA_OFS, PA_DIR_OFS,
                PC_DATA_OFS, PC_DIR_OFS};
        foreach (ofs[i]) begin
            bus(1'b0, ofs[i], 8'h00);
            check(rdat, 32'h0);
        end
        wr(6'h20, 8'hff);
        // a write without the low byte lane must be ignored
        avs_byteenable <= 4'he;
        wr(SYS_CFG_OFS, 8'hff);
        avs_byteenable <= 4'h1;
        bus(1'b0, 6'h20, 8'h00);
        check(rdat, 32'h0);
        bus(1'b0, SYS_CFG_OFS, 8'h00);
        check(rdat, 32'h0);
        wr(PA_PINS_OFS, 8'h00);
        bus(1'b0, PA_PINS_OFS, 8'h00);
        check(rdat, {24'h0, paExt});
    endtask

    task automatic t_host;
        logic [13:0] hExp;
        for (int m = 0; m < 2; m++) begin
            cfg({6'h00, m[0], 1'b0}, 8'h00);
            wr(PA_DIR_OFS, 8'hff);
            wr(PA_DATA_OFS, 8'h5a);
            hostOut <= {8'hc3, 1'b1, 1'b0, 3'b101};
            chbOut <= {7'h55, 7'h41, 3'b010};
            settle();
            hExp = {8'hc3, chbExt[3], chbExt[1], chbExt[2], chbExt[4],
                    chbExt[6], chbExt[5]};
            if (m == 1) begin
                check({paPinOut, paPinOe}, {8'hc3, 8'hff});
                check(hostIn, hExp);
                check({chbPinOe, chbPinOut[0]}, {7'h01, 1'b0});
                check(chbIn, 7'h7f);
            end else begin
                check({paPinOut, paPinOe}, {8'h5a, 8'hff});
                check(hostIn, {8'h00, 6'h3f});
                check({chbPinOe, chbPinOut & 7'h41}, 14'h20c1);
                check(chbIn, 7'h41 | (chbExt & 7'h3e));
            end
        end
    endtask

    // each mode gives its own source the odd value, so a wrong pick shows
    task automatic t_tri;
        for (int m = 0; m < 3; m++) begin
            cfg({5'h00, m == 1, m == 2, 1'b0}, 8'h00);
            mpuOut.ckaO <= (m == 0);
            mpuOut.ckaOe <= 1'b1;
            mpuOut.tend1N <= (m != 0);
            chbOut.dtrReqN <= (m == 1);
            chbOut.waitReqN <= (m == 1);
            chbOut.rtsN <= (m != 1);
            hostOut.intr <= (m == 2);
            hostOut.txRdyN <= (m == 2);
            hostOut.rxRdyN <= (m != 2);
            settle();
            check(triPinOe, (m == 0) ? 3'b101 : 3'b111);
            check(triPinOut, 3'b011);
            check(mpuIn.dreq1N, (m == 0) ? triExt[1] : 1'b1);
        end
    endtask

    task automatic t_strobe;
        for (int m = 0; m < 4; m++) begin
            cfg({m[1], 7'h00}, {4'h0, m[0], m[1], 2'b00});
            wr(PC_DIR_OFS, 8'h04);
            wr(PC_DATA_OFS, (m == 3) ? 8'h00 : 8'h04);
            mpuOut.mrdN <= m[0];
            mpuOut.mreqN <= ~m[0];
            mpuOut.mwrN <= m[0];
            mpuOut.chain_enable_output <= m[0];
            chaOut.rtsN <= (m != 1);
            chainExt <= m[0];
            settle();
            check(mrdPinOut, 1'b0);
            check({wrPinOe, wrPinOut}, 2'b10);
            check({chainPinOe, chainPinOut}, {m[1], m[0]});
            check(mpuIn.chain_enable_input, m[1] | m[0]);
        end
    endtask

    task automatic t_portc;
        for (int b = 0; b < 2; b++) begin
            cfg({b[0], 7'h00}, 8'h00);
            wr(PC_DIR_OFS, 8'hff);
            wr(PC_DATA_OFS, 8'h2a);
            chaOut <= 3'b010;
            intPinIn <= b[0] ? 2'b01 : 2'b10;
            bus(1'b0, PC_DIR_OFS, 8'h00);
            check(rdat, 32'h3f);
            settle();
            bus(1'b0, PC_PINS_OFS, 8'h00);
            check(rdat & 32'hc0, {24'h0, intPinIn, 6'h00});
            check({mpuIn.int2N, mpuIn.int1N}, intPinIn);
            if (b == 1) begin
                check({chaPinOe, chaPinOut}, {5'h1f, 5'h16});
                check(chaIn, 3'h7);
            end else begin
                check({chaPinOe, chaPinOut & 5'h14}, 10'h284);
                check(chaIn, {chaExt[1], chaExt[0], chaExt[3]});
            end
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'h1;
        paExt = 8'h96;
        chbExt = 7'h2b;
        triExt = 3'b101;
        chaExt = 5'h0b;
        wrExt = 1'b1;
        chainExt = 1'b0;
        intPinIn = 2'b10;
        chbOut = '0;
        hostOut = '0;
        chaOut = '0;
        mpuOut = '0;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        t_regs();
        t_host();
        t_tri();
        t_strobe();
        t_portc();
        end_of_test();
    end

    // the whole run needs well under a thousand cycles
    initial begin
        #200000;
        errTotal++;
        end_of_test();
    end
endmodule // shared_pin_function_mux_tb
`default_nettype wire
